// >>> logic/sfx_pkg.sv
// Register map, field layout and shared types of the register-extension block
package sfx_pkg;

    // Register addresses on the core's special register bus
    localparam logic [7:0] ADDR_POWER      = 8'h87;
    localparam logic [7:0] ADDR_AUX        = 8'h8e;
    localparam logic [7:0] ADDR_WDOG       = 8'h8f;
    localparam logic [7:0] ADDR_XIC        = 8'hc0;
    localparam logic [7:0] ADDR_NIB        = 8'hd8;

    // Extra interrupt control: per source a group of four bits, source two low
    localparam int unsigned XIC_IT         = 0;
    localparam int unsigned XIC_IE         = 1;
    localparam int unsigned XIC_EX         = 2;
    localparam int unsigned XIC_PX         = 3;
    localparam int unsigned XIC_STRIDE     = 4;
    localparam int unsigned NIB_PIN_FIRST  = 2;

    // Power control bits
    localparam int unsigned PWR_POF        = 4;
    localparam int unsigned PWR_GF1        = 3;
    localparam int unsigned PWR_GF0        = 2;
    localparam int unsigned PWR_PD         = 1;
    localparam int unsigned PWR_IDL        = 0;

    // Auxiliary and watchdog control bits
    localparam int unsigned AUX_AO         = 0;
    localparam int unsigned WD_ENW         = 7;
    localparam int unsigned WD_WATCHDOG_CLEAR        = 6;
    localparam int unsigned WD_WATCHDOG_IN_IDLE        = 3;
    localparam int unsigned WD_PS_LSB      = 0;

    // Interrupt vectors and polling positions of the two extra sources
    localparam logic [7:0] VEC_TWO         = 8'h33;
    localparam logic [7:0] VEC_THREE       = 8'h3b;
    localparam logic [2:0] POLL_TWO        = 3'h5;
    localparam logic [2:0] POLL_THREE      = 3'h6;

    // Reset values
    localparam logic [7:0] XIC_RST         = 8'h00;
    localparam logic [3:0] NIB_RST         = 4'hf;
    localparam logic [2:0] PS_RST          = 3'h0;

    // Timing: oscillator periods per machine cycle, watchdog timer length
    localparam int unsigned MC_OSC_PERIODS = 12;
    localparam int unsigned WD_TIMER_BITS  = 14;
    localparam int unsigned MC_CNT_W       = 4;
    localparam int unsigned PRE_CNT_W      = 8;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [7:0] bit_addr;
        logic       bit_val;
    } sfx_bus_req_type;

    typedef struct packed {
        logic       req;
        logic       high;
        logic [2:0] poll;
        logic [7:0] vector;
    } sfx_irq_type;

    typedef struct packed {
        logic [3:0]                 pin_meta;
        logic [3:0]                 pin_s;
        logic [3:0]                 pin_prev;
        logic [7:0]                 xic;
        logic [3:0]                 nib;
        logic                       aux_ao;
        logic                       gf1;
        logic                       gf0;
        logic                       pd;
        logic                       idle_bit;
        logic                       wd_en;
        logic                       wd_clr;
        logic                       wd_idle;
        logic [2:0]                 wd_ps;
        logic [MC_CNT_W-1:0]        mc_cnt;
        logic [PRE_CNT_W-1:0]       pre_cnt;
        logic [WD_TIMER_BITS-1:0]   wd_cnt;
        logic                       wd_rst;
        logic [1:0]                 irq_req;
        logic [1:0]                 irq_high;
        logic                       ale;
        logic [7:0]                 rdata;
    } sfx_state_type;

endpackage

// >>> logic/sfx_regs.sv
// Extra interrupts, nibble port, strobe suppression, power control and watchdog
`timescale 1ns/1ps
`default_nettype none

module sfx_regs #(
    parameter int unsigned MC_DIV   = sfx_pkg::MC_OSC_PERIODS,
    parameter int unsigned WD_BITS  = sfx_pkg::WD_TIMER_BITS
) (
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST,
    input  wire logic                    POWER_ON,
    input  wire sfx_pkg::sfx_bus_req_type SFR_REQ,
    output logic [7:0]                   SFR_RDATA,
    input  wire logic [1:0]              IRQ_ACK,
    input  wire logic                    WAKE_IRQ,
    output sfx_pkg::sfx_irq_type         IRQ_TWO,
    output sfx_pkg::sfx_irq_type         IRQ_THREE,
    input  wire logic [3:0]              NIB_PIN_IN,
    output logic [3:0]                   NIB_PIN_OUT,
    output logic [3:0]                   NIB_PIN_OE,
    input  wire logic                    ALE_TIMING,
    input  wire logic                    EXT_ACCESS,
    output logic                         ALE_OUT,
    output logic                         IDLE_MODE,
    output logic                         POWER_DOWN,
    output logic                         WDT_RESET
);

    // Refuse sizes that the counters cannot hold
    if (MC_DIV < 1 || MC_DIV > (1 << sfx_pkg::MC_CNT_W)) begin : g_bad_mc_div
        $error("MC_DIV out of range");
    end
    if (WD_BITS < 1 || WD_BITS > sfx_pkg::WD_TIMER_BITS) begin : g_bad_wd_bits
        $error("WD_BITS out of range");
    end

    localparam logic [sfx_pkg::MC_CNT_W-1:0] MC_LAST = sfx_pkg::MC_CNT_W'(MC_DIV - 1);

    sfx_pkg::sfx_state_type s;
    sfx_pkg::sfx_state_type next_s;

    // Power flag lives outside the reset group: a warm reset must not touch it
    logic power_on_flag;
    logic por_meta;
    logic por_s;

    logic                          mc_tick;
    logic                          wd_run;
    logic                          pre_wrap;
    logic                          wd_full;
    logic [sfx_pkg::PRE_CNT_W-1:0] ratio_m1;
    logic [7:0]                    xic_w;
    logic [7:0]                    nib_w;
    logic [1:0]                    fall;
    logic                          pwr_wr;
    logic                          wd_wr;

    // Byte write or bit instruction on a bit-addressable register
    function automatic logic [7:0] sfr_upd(input logic [7:0] cur,
                                           input logic [7:0] base,
                                           input sfx_pkg::sfx_bus_req_type rq);
        logic [7:0] v;
        v = cur;
        if (rq.wr && rq.addr == base) begin
            v = rq.wdata;
        end
        if (rq.bit_wr && rq.bit_addr[7:3] == base[7:3]) begin
            v[rq.bit_addr[2:0]] = rq.bit_val;
        end
        return v;
    endfunction

    function automatic logic byte_wr(input logic [7:0] base,
                                     input sfx_pkg::sfx_bus_req_type rq);
        return rq.wr && rq.addr == base;
    endfunction

    always_comb begin
        next_s   = s;
        pwr_wr   = byte_wr(sfx_pkg::ADDR_POWER, SFR_REQ);
        wd_wr    = byte_wr(sfx_pkg::ADDR_WDOG, SFR_REQ);
        mc_tick  = (s.mc_cnt == MC_LAST);
        // Idle freezes the watchdog unless the idle-enable bit keeps it alive
        wd_run   = s.wd_en && (!s.idle_bit || s.wd_idle);
        ratio_m1 = sfx_pkg::PRE_CNT_W'((9'h002 << s.wd_ps) - 9'h001);
        pre_wrap = (s.pre_cnt == ratio_m1);
        wd_full  = &s.wd_cnt[WD_BITS-1:0];

        // Pins pass two flops before any logic; a third stage gives the edge
        next_s.pin_meta = NIB_PIN_IN;
        next_s.pin_s    = s.pin_meta;
        next_s.pin_prev = s.pin_s;

        xic_w = sfr_upd(s.xic, sfx_pkg::ADDR_XIC, SFR_REQ);
        for (int i = 0; i < 2; i++) begin
            fall[i] = s.pin_prev[sfx_pkg::NIB_PIN_FIRST + i]
                      && !s.pin_s[sfx_pkg::NIB_PIN_FIRST + i];
            if (xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_IT]) begin
                // Clear on service first so a coincident edge still wins
                if (IRQ_ACK[i]) begin
                    xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_IE] = 1'b0;
                end
                if (fall[i]) begin
                    xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_IE] = 1'b1;
                end
            end else begin
                xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_IE] =
                    !s.pin_s[sfx_pkg::NIB_PIN_FIRST + i];
            end
            next_s.irq_req[i]  = xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_EX]
                                 && xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_IE];
            next_s.irq_high[i] = xic_w[sfx_pkg::XIC_STRIDE * i + sfx_pkg::XIC_PX];
        end
        next_s.xic = xic_w;

        nib_w      = sfr_upd({4'hf, s.nib}, sfx_pkg::ADDR_NIB, SFR_REQ);
        next_s.nib = nib_w[3:0];

        if (byte_wr(sfx_pkg::ADDR_AUX, SFR_REQ)) begin
            next_s.aux_ao = SFR_REQ.wdata[sfx_pkg::AUX_AO];
        end
        // Suppressed strobe still follows the core timing during external cycles
        next_s.ale = ALE_TIMING && (!s.aux_ao || EXT_ACCESS);

        if (pwr_wr) begin
            next_s.gf1 = SFR_REQ.wdata[sfx_pkg::PWR_GF1];
            next_s.gf0 = SFR_REQ.wdata[sfx_pkg::PWR_GF0];
            next_s.pd  = SFR_REQ.wdata[sfx_pkg::PWR_PD];
            next_s.idle_bit = SFR_REQ.wdata[sfx_pkg::PWR_IDL];
        end
        // A pending request ends idle at once, even one that raced the write
        if (WAKE_IRQ || |s.irq_req) begin
            next_s.idle_bit = 1'b0;
        end

        next_s.mc_cnt = mc_tick ? '0 : s.mc_cnt + 1'b1;
        next_s.wd_rst = 1'b0;
        if (s.wd_clr && mc_tick) begin
            next_s.pre_cnt = '0;
            next_s.wd_cnt  = '0;
            next_s.wd_clr  = 1'b0;
        end else if (wd_run && mc_tick) begin
            if (pre_wrap) begin
                next_s.pre_cnt = '0;
                next_s.wd_cnt  = wd_full ? '0 : s.wd_cnt + 1'b1;
                next_s.wd_rst  = wd_full;
            end else begin
                next_s.pre_cnt = s.pre_cnt + 1'b1;
            end
        end
        if (wd_wr) begin
            next_s.wd_en   = SFR_REQ.wdata[sfx_pkg::WD_ENW];
            next_s.wd_idle = SFR_REQ.wdata[sfx_pkg::WD_WATCHDOG_IN_IDLE];
            next_s.wd_ps   = SFR_REQ.wdata[sfx_pkg::WD_PS_LSB +: 3];
            if (SFR_REQ.wdata[sfx_pkg::WD_WATCHDOG_CLEAR]) begin
                next_s.wd_clr = 1'b1;
            end
        end

        next_s.rdata = 8'h00;
        if (SFR_REQ.rd) begin
            case (SFR_REQ.addr)
                sfx_pkg::ADDR_POWER: begin
                    next_s.rdata[sfx_pkg::PWR_POF] = power_on_flag;
                    next_s.rdata[sfx_pkg::PWR_GF1] = s.gf1;
                    next_s.rdata[sfx_pkg::PWR_GF0] = s.gf0;
                    next_s.rdata[sfx_pkg::PWR_PD]  = s.pd;
                    next_s.rdata[sfx_pkg::PWR_IDL] = s.idle_bit;
                end
                sfx_pkg::ADDR_AUX: begin
                    next_s.rdata[sfx_pkg::AUX_AO] = s.aux_ao;
                end
                sfx_pkg::ADDR_WDOG: begin
                    next_s.rdata[sfx_pkg::WD_ENW]          = s.wd_en;
                    next_s.rdata[sfx_pkg::WD_WATCHDOG_CLEAR]         = s.wd_clr;
                    next_s.rdata[sfx_pkg::WD_WATCHDOG_IN_IDLE]         = s.wd_idle;
                    next_s.rdata[sfx_pkg::WD_PS_LSB +: 3]  = s.wd_ps;
                end
                sfx_pkg::ADDR_XIC: begin
                    next_s.rdata = s.xic;
                end
                sfx_pkg::ADDR_NIB: begin
                    // Reads return the pin levels, as on a pulled-up port
                    next_s.rdata = {4'h0, s.pin_s};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s          <= '0;
            s.pin_meta <= 4'hf;
            s.pin_s    <= 4'hf;
            s.pin_prev <= 4'hf;
            s.xic      <= sfx_pkg::XIC_RST;
            s.nib      <= sfx_pkg::NIB_RST;
            s.wd_ps    <= sfx_pkg::PS_RST;
        end else begin
            s <= next_s;
        end
    end

    // Power-on detector is asynchronous to the core clock, hence the synchroniser
    always_ff @(posedge CORE_CLK) begin
        por_meta <= POWER_ON;
        por_s    <= por_meta;
        if (por_s) begin
            power_on_flag <= 1'b1;
        end else if (byte_wr(sfx_pkg::ADDR_POWER, SFR_REQ)) begin
            power_on_flag <= SFR_REQ.wdata[sfx_pkg::PWR_POF];
        end
    end

    // Open-drain style pulled-up port: drive only the zeros
    assign NIB_PIN_OUT = 4'h0;
    assign NIB_PIN_OE  = ~s.nib;
    assign SFR_RDATA   = s.rdata;
    assign ALE_OUT     = s.ale;
    assign IDLE_MODE   = s.idle_bit;
    assign POWER_DOWN  = s.pd;
    assign WDT_RESET   = s.wd_rst;
    assign IRQ_TWO     = '{req: s.irq_req[0], high: s.irq_high[0],
                           poll: sfx_pkg::POLL_TWO, vector: sfx_pkg::VEC_TWO};
    assign IRQ_THREE   = '{req: s.irq_req[1], high: s.irq_high[1],
                           poll: sfx_pkg::POLL_THREE, vector: sfx_pkg::VEC_THREE};

    chk_byte_prio: assert property (@(posedge CORE_CLK) disable iff (RST)
        byte_wr(sfx_pkg::ADDR_XIC, SFR_REQ) && !SFR_REQ.bit_wr
        |=> IRQ_TWO.high == $past(SFR_REQ.wdata[3]) && IRQ_THREE.high == $past(SFR_REQ.wdata[7]))
        else $error("priority bits do not follow byte write");

    chk_bit_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
        SFR_REQ.bit_wr && SFR_REQ.bit_addr == 8'hc2 && SFR_REQ.bit_val
        && !byte_wr(sfx_pkg::ADDR_XIC, SFR_REQ) |=> s.xic[2])
        else $error("bit set at c2 did not enable source two");

    chk_edge_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.xic[0] && fall[0] && !SFR_REQ.wr && !SFR_REQ.bit_wr
        |=> s.xic[1] && IRQ_TWO.req == s.xic[2])
        else $error("falling edge did not raise flag");

    chk_ack_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.xic[4] && IRQ_ACK[1] && !fall[1] && !SFR_REQ.wr && !SFR_REQ.bit_wr |=> !s.xic[5])
        else $error("service did not clear edge flag");

    chk_level_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s.xic[0] && !SFR_REQ.wr && !SFR_REQ.bit_wr |=> s.xic[1] == !$past(s.pin_s[2]))
        else $error("level flag does not follow pin");

    chk_req_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
        IRQ_THREE.req |-> s.xic[6] && s.xic[5])
        else $error("request without enable");

    chk_ale_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.aux_ao && !EXT_ACCESS |=> !ALE_OUT)
        else $error("strobe toggled while suppressed");

    chk_wd_frozen: assert property (@(posedge CORE_CLK) disable iff (RST)
        (!s.wd_en || (s.idle_bit && !s.wd_idle)) && !s.wd_clr |=> $stable(s.wd_cnt))
        else $error("watchdog counted while stopped");

    chk_wd_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.wd_clr && mc_tick |=> s.wd_cnt == '0 && s.pre_cnt == '0)
        else $error("clear did not reset timer and prescaler");

    chk_mc_period: assert property (@(posedge CORE_CLK) disable iff (RST)
        mc_tick |-> ##12 mc_tick)
        else $error("machine cycle is not twelve clocks");

    chk_idle_wake: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.idle_bit && WAKE_IRQ |=> !IDLE_MODE)
        else $error("interrupt did not end idle");

    chk_ack_two: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.xic[0] && IRQ_ACK[0] && !fall[0] && !SFR_REQ.wr && !SFR_REQ.bit_wr |=> !s.xic[1])
        else $error("service did not clear source two flag");

    chk_edge_three: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.xic[4] && fall[1] && !SFR_REQ.wr && !SFR_REQ.bit_wr |=> s.xic[5])
        else $error("falling edge did not raise source three flag");

    chk_level_three: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s.xic[4] && !SFR_REQ.wr && !SFR_REQ.bit_wr |=> s.xic[5] == !$past(s.pin_s[3]))
        else $error("level flag of source three does not follow pin");

    chk_req_two: assert property (@(posedge CORE_CLK) disable iff (RST)
        IRQ_TWO.req |-> s.xic[2] && s.xic[1])
        else $error("source two request without enable");

    chk_prio_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        !SFR_REQ.wr && !SFR_REQ.bit_wr |=> $stable(IRQ_TWO.high) && $stable(IRQ_THREE.high))
        else $error("priority changed without a write");

    chk_pof_set: assert property (@(posedge CORE_CLK) disable iff (RST)
        por_s |=> power_on_flag)
        else $error("power flag not set by power-on");

    chk_pof_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        !por_s && !pwr_wr |=> $stable(power_on_flag))
        else $error("power flag changed without power-on or write");

    chk_user_flags: assert property (@(posedge CORE_CLK) disable iff (RST)
        pwr_wr |=> {s.gf1, s.gf0} == $past(SFR_REQ.wdata[3:2]))
        else $error("user flags do not follow write");

    chk_pd_enter: assert property (@(posedge CORE_CLK) disable iff (RST)
        pwr_wr && SFR_REQ.wdata[1] |=> POWER_DOWN)
        else $error("power-down bit did not enter power-down");

    chk_idle_enter: assert property (@(posedge CORE_CLK) disable iff (RST)
        pwr_wr && SFR_REQ.wdata[0] && !WAKE_IRQ && s.irq_req == 2'h0 |=> IDLE_MODE)
        else $error("idle bit did not enter idle");

    chk_port_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
        byte_wr(sfx_pkg::ADDR_NIB, SFR_REQ) && !SFR_REQ.bit_wr
        |=> NIB_PIN_OE == ~$past(SFR_REQ.wdata[3:0]))
        else $error("port drive does not follow byte write");

    chk_ale_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
        !s.aux_ao |=> ALE_OUT == $past(ALE_TIMING))
        else $error("strobe does not follow core timing");

    chk_wd_pulse: assert property (@(posedge CORE_CLK) disable iff (RST)
        WDT_RESET |=> !WDT_RESET)
        else $error("time-out pulse longer than one cycle");

    chk_clr_pending: assert property (@(posedge CORE_CLK) disable iff (RST)
        s.wd_clr && !mc_tick |=> s.wd_clr)
        else $error("clear bit dropped before machine cycle");

    // Watches reset itself, so it carries no disable
    chk_wd_off_reset: assert property (@(posedge CORE_CLK)
        RST |=> !s.wd_en && s.wd_cnt == '0 && s.pre_cnt == '0)
        else $error("reset did not stop and clear the watchdog");

    cov_edge_req: cover property (@(posedge CORE_CLK) disable iff (RST)
        s.xic[0] && fall[0] ##1 IRQ_TWO.req);
    cov_wd_timeout: cover property (@(posedge CORE_CLK) disable iff (RST) WDT_RESET);
    cov_ale_ext: cover property (@(posedge CORE_CLK) disable iff (RST)
        s.aux_ao && EXT_ACCESS && ALE_TIMING ##1 ALE_OUT);
    cov_idle_exit: cover property (@(posedge CORE_CLK) disable iff (RST)
        IDLE_MODE ##1 !IDLE_MODE);
    cov_wd_clear: cover property (@(posedge CORE_CLK) disable iff (RST) s.wd_clr && mc_tick);

endmodule

`default_nettype wire

// >>> test/sfx_core_model.sv
// Core-side model: register bus requests, interrupt service and port pin drivers
`timescale 1ns/1ps
`default_nettype none
module sfx_core_model (
    input  wire logic                  CORE_CLK,
    output var sfx_pkg::sfx_bus_req_type SFR_REQ,
    input  wire logic [7:0]            SFR_RDATA,
    output logic [1:0]                 IRQ_ACK,
    output logic                       WAKE_IRQ,
    input  wire logic [3:0]            NIB_PIN_OE,
    input  wire logic [3:0]            NIB_PIN_OUT,
    output logic [3:0]                 NIB_PIN_IN
);
    logic [3:0] ext_low;
    // Pulled-up wire: low when either side pulls it down
    assign NIB_PIN_IN = (NIB_PIN_OE & NIB_PIN_OUT | ~NIB_PIN_OE) & ~ext_low;
    initial begin
        SFR_REQ = '0;
        IRQ_ACK = 2'h0;
        WAKE_IRQ = 1'b0;
        ext_low = 4'h0;
    end
    // Requests change just after an edge and drop just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CORE_CLK);
        #1;
        SFR_REQ.wr = 1'b1;
        SFR_REQ.addr = a;
        SFR_REQ.wdata = v;
        @(posedge CORE_CLK);
        #1;
        SFR_REQ = '0;
    endtask
    task automatic bwr(input logic [7:0] a, input logic v);
        @(posedge CORE_CLK);
        #1;
        SFR_REQ.bit_wr = 1'b1;
        SFR_REQ.bit_addr = a;
        SFR_REQ.bit_val = v;
        @(posedge CORE_CLK);
        #1;
        SFR_REQ = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge CORE_CLK);
        #1;
        SFR_REQ.rd = 1'b1;
        SFR_REQ.addr = a;
        @(posedge CORE_CLK);
        #1;
        SFR_REQ = '0;
        v = SFR_RDATA;
    endtask
    task automatic ack(input int i);
        @(posedge CORE_CLK);
        #1;
        IRQ_ACK[i] = 1'b1;
        @(posedge CORE_CLK);
        #1;
        IRQ_ACK = 2'h0;
    endtask
    task automatic wake();
        @(posedge CORE_CLK);
        #1;
        WAKE_IRQ = 1'b1;
        @(posedge CORE_CLK);
        #1;
        WAKE_IRQ = 1'b0;
    endtask
    task automatic pin(input int i, input logic low);
        ext_low[i] = low;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_sfx_regs.sv
// Self-checking bench for the register-extension block
`timescale 1ns/1ps
`default_nettype none
module tb_sfx_regs;
    localparam int unsigned WDB = 2;
    logic                     core_clk, rst, power_on, ale_timing, ext_access;
    sfx_pkg::sfx_bus_req_type sfr_req;
    logic [7:0]               sfr_rdata, d;
    logic [1:0]               irq_ack;
    logic                     wake_irq, ale_out, idle_mode, power_down, wdt_reset;
    sfx_pkg::sfx_irq_type     irq_two, irq_three;
    logic [3:0]               pin_in, pin_out, pin_oe;
    int                       n_fail, checks, cycles, n_wdt, n, base;
    logic [7:0]               ra [6] = '{8'h87, 8'h8e, 8'h8f, 8'hc0, 8'hd8, 8'h90};
    logic [7:0]               rv [6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};

    sfx_core_model u_core (.CORE_CLK(core_clk), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
        .IRQ_ACK(irq_ack), .WAKE_IRQ(wake_irq), .NIB_PIN_OE(pin_oe),
        .NIB_PIN_OUT(pin_out), .NIB_PIN_IN(pin_in));
    sfx_regs #(.MC_DIV(12), .WD_BITS(WDB)) u_dut (.CORE_CLK(core_clk), .RST(rst),
        .POWER_ON(power_on), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata), .IRQ_ACK(irq_ack),
        .WAKE_IRQ(wake_irq), .IRQ_TWO(irq_two), .IRQ_THREE(irq_three), .NIB_PIN_IN(pin_in),
        .NIB_PIN_OUT(pin_out), .NIB_PIN_OE(pin_oe), .ALE_TIMING(ale_timing),
        .EXT_ACCESS(ext_access), .ALE_OUT(ale_out), .IDLE_MODE(idle_mode),
        .POWER_DOWN(power_down), .WDT_RESET(wdt_reset));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard: the whole sequence needs about 1500 cycles
    // Falling edge, so the registered pulse has settled when it is counted
    always @(negedge core_clk) begin
        cycles++;
        if (wdt_reset === 1'b1) n_wdt++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
    endtask
    // Cycles until the next time-out pulse, bounded
    task automatic wait_wdt(input int lim, output int c);
        c = 0;
        while (c < lim && wdt_reset !== 1'b1) begin
            tick(1);
            c++;
        end
    endtask

    initial begin
        rst = 1'b1;
        power_on = 1'b1;
        ale_timing = 1'b0;
        ext_access = 1'b0;
        tick(4);
        rst = 1'b0;
        tick(4);
        power_on = 1'b0;
        for (int i = 0; i < 6; i++) begin
            u_core.rd(ra[i], d);
            check(d, rv[i]);
        end
        // Edge source two: disabled first, then bit-set enable
        u_core.wr(8'hc0, 8'h09);
        u_core.pin(2, 1'b1);
        tick(6);
        check(8'(irq_two.req), 8'h00);
        u_core.bwr(8'hc2, 1'b1);
        tick(1);
        check(8'(irq_two.req), 8'h01);
        check(8'(irq_two.high), 8'h01);
        check(irq_two.vector, 8'h33);
        check(8'(irq_two.poll), 8'h05);
        u_core.pin(2, 1'b0);
        u_core.rd(8'hc0, d);
        check(d, 8'h0f);
        u_core.ack(0);
        check(8'(irq_two.req), 8'h00);
        // Level source three
        u_core.wr(8'hc0, 8'h40);
        u_core.pin(3, 1'b1);
        tick(6);
        check(8'(irq_three.req), 8'h01);
        check(8'(irq_three.high), 8'h00);
        check(irq_three.vector, 8'h3b);
        check(8'(irq_three.poll), 8'h06);
        u_core.pin(3, 1'b0);
        tick(6);
        check(8'(irq_three.req), 8'h00);
        // Edge source three: flag set by software, then serviced
        u_core.wr(8'hc0, 8'h70);
        check(8'(irq_three.req), 8'h01);
        u_core.ack(1);
        check(8'(irq_three.req), 8'h00);
        // Nibble port
        u_core.wr(8'hc0, 8'h00);
        u_core.wr(8'hd8, 8'h0a);
        check(8'(pin_oe), 8'h05);
        check(8'(pin_out), 8'h00);
        tick(3);
        u_core.rd(8'hd8, d);
        check(d, 8'h0a);
        u_core.bwr(8'hd8, 1'b1);
        check(8'(pin_oe), 8'h04);
        u_core.wr(8'hd8, 8'h0f);
        // Address strobe suppression
        ale_timing = 1'b1;
        tick(2);
        check(8'(ale_out), 8'h01);
        u_core.wr(8'h8e, 8'h01);
        tick(2);
        check(8'(ale_out), 8'h00);
        ext_access = 1'b1;
        tick(2);
        check(8'(ale_out), 8'h01);
        ext_access = 1'b0;
        tick(2);
        check(8'(ale_out), 8'h00);
        // Power control flags
        u_core.wr(8'h87, 8'h0c);
        u_core.rd(8'h87, d);
        check(d, 8'h0c);
        do_reset();
        u_core.rd(8'h87, d);
        check(d, 8'h00);
        // Watchdog: 2^WDB timer steps of ratio 2^(ps+1) machine cycles
        u_core.wr(8'h8f, 8'h80);
        wait_wdt(300, n);
        check(8'(n >= 84 && n <= 108), 8'h01);
        u_core.wr(8'h8f, 8'h81);
        wait_wdt(400, n);
        check(8'(n >= 168 && n <= 216), 8'h01);
        // Let the pulse just seen be counted before taking the base
        tick(1);
        base = n_wdt;
        for (int i = 0; i < 6; i++) begin
            tick(60);
            u_core.wr(8'h8f, 8'hc1);
        end
        u_core.wr(8'h8f, 8'h01);
        tick(300);
        check(8'(n_wdt - base), 8'h00);
        u_core.wr(8'h8f, 8'h80);
        u_core.wr(8'h87, 8'h01);
        check(8'(idle_mode), 8'h01);
        tick(300);
        check(8'(n_wdt - base), 8'h00);
        u_core.wake();
        check(8'(idle_mode), 8'h00);
        u_core.wr(8'h8f, 8'h88);
        u_core.wr(8'h87, 8'h01);
        wait_wdt(300, n);
        check(8'(n < 300), 8'h01);
        u_core.wr(8'h87, 8'h02);
        check(8'(power_down), 8'h01);
        do_reset();
        check(8'(power_down), 8'h00);
        u_core.rd(8'h8f, d);
        check(d, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
